// [hw/acas_defines.vh]
// Purpose: Offsets, reset values and widths of the alert status bank
// Assumes: Included by acas_alert_status.v only
// Notes: Guarded against double inclusion
`ifndef ACAS_DEFINES_VH
`define ACAS_DEFINES_VH
`define ACAS_ADDR_W 8
`define ACAS_DATA_W 16
`define ACAS_AUX_N 6
`define ACAS_CELL_N 14
`define ACAS_ADC_W 14
`define ACAS_OFF_AUX_OVER 8'h0C
`define ACAS_OFF_AUX_UNDER 8'h0D
`define ACAS_OFF_CELL_OVER 8'h0E
`define ACAS_RST_AUX_OVER 6'h00
`define ACAS_RST_AUX_UNDER 6'h00
`define ACAS_RST_CELL_OVER 14'h0000
`endif

// [hw/acas_alert_status.v]
// Purpose: Auxiliary and comparator cell alert status registers
// Assumes: Acquisition results arrive on clk with a one-cycle done strobe
// Notes: Registers are read only; host writes have no effect
`timescale 1ns/1ps
`default_nettype none
`include "acas_defines.vh"

// Operation
// - Each aux over alert sets when its input exceeds the over threshold while enabled.
// - An aux over alert holds until the next acquisition and clears then only if the condition is gone.
// - Each aux under alert sets when its input is below the under threshold while enabled.
// - An aux under alert holds until the next acquisition and clears then only if the condition is gone.
// - Each cell comparator over alert sets when the comparator sees the cell above its threshold while enabled.
// - A cell comparator alert clears only at the next comparator acquisition if resolved; main acquisitions leave it.
// - Aux under alerts read at offset 0x0D in bits 5:0, reset zero, upper bits zero.
// - Cell comparator alerts read at offset 0x0E in bits 13:0, reset zero, bits 15:14 zero.
// - Aux over alerts read at offset 0x0C in bits 5:0, reset zero.
module acas_alert_status #(
    parameter AUX_N = `ACAS_AUX_N,
    parameter CELL_N = `ACAS_CELL_N,
    parameter ADC_W = `ACAS_ADC_W
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Main acquisition engine
    input wire adc_done,
    input wire [AUX_N*ADC_W-1:0] aux_input_voltage,
    input wire [ADC_W-1:0] aux_over_threshold,
    input wire [ADC_W-1:0] aux_under_threshold,
    input wire [AUX_N-1:0] aux_over_alert_enable,
    input wire [AUX_N-1:0] aux_under_alert_enable,
    // Redundant comparator engine
    input wire cmp_done,
    input wire [CELL_N-1:0] cmp_cell_above,
    input wire [CELL_N-1:0] cell_over_alert_enable,
    // Host port
    input wire reg_rd,
    input wire reg_wr,
    input wire [`ACAS_ADDR_W-1:0] reg_addr,
    input wire [`ACAS_DATA_W-1:0] reg_wdata,
    output reg [`ACAS_DATA_W-1:0] reg_rdata,
    output reg reg_rvalid,
    // Alert levels
    output wire [AUX_N-1:0] aux_over_alert,
    output wire [AUX_N-1:0] aux_under_alert,
    output wire [CELL_N-1:0] cell_cmp_over_alert
);

    // Register selects decoded from the host address
    localparam SEL_NONE = 2'b00;
    localparam SEL_AUX_OVER = 2'b01;
    localparam SEL_AUX_UNDER = 2'b10;
    localparam SEL_CELL_OVER = 2'b11;
    localparam [AUX_N-1:0] RST_AUX_OVER = `ACAS_RST_AUX_OVER;
    localparam [AUX_N-1:0] RST_AUX_UNDER = `ACAS_RST_AUX_UNDER;
    localparam [CELL_N-1:0] RST_CELL_OVER = `ACAS_RST_CELL_OVER;

    // Reset synchroniser
    reg rst_s1_q;
    reg rst_s2_q;
    wire rst_sync_n;
    // Compare results
    wire [AUX_N-1:0] aux_over_hit;
    wire [AUX_N-1:0] aux_under_hit;
    wire [CELL_N-1:0] cell_over_hit;
    // Alert state
    reg [AUX_N-1:0] aux_over_q;
    reg [AUX_N-1:0] aux_over_d;
    reg [AUX_N-1:0] aux_under_q;
    reg [AUX_N-1:0] aux_under_d;
    reg [CELL_N-1:0] cell_over_q;
    reg [CELL_N-1:0] cell_over_d;
    // Read path
    wire rd_take;
    wire [1:0] rd_sel;
    reg [`ACAS_DATA_W-1:0] rdata_d;
    genvar g;

    function [1:0] reg_select;
        input [`ACAS_ADDR_W-1:0] addr;
        begin
            case (addr)
                `ACAS_OFF_AUX_OVER: begin
                    reg_select = SEL_AUX_OVER;
                end
                `ACAS_OFF_AUX_UNDER: begin
                    reg_select = SEL_AUX_UNDER;
                end
                `ACAS_OFF_CELL_OVER: begin
                    reg_select = SEL_CELL_OVER;
                end
                default: begin
                    reg_select = SEL_NONE;
                end
            endcase
        end
    endfunction

    // Unused upper bits read zero
    function [`ACAS_DATA_W-1:0] widen_aux;
        input [AUX_N-1:0] bits;
        begin
            widen_aux = {`ACAS_DATA_W{1'b0}};
            widen_aux[AUX_N-1:0] = bits;
        end
    endfunction

    function [`ACAS_DATA_W-1:0] widen_cell;
        input [CELL_N-1:0] bits;
        begin
            widen_cell = {`ACAS_DATA_W{1'b0}};
            widen_cell[CELL_N-1:0] = bits;
        end
    endfunction

    // Release is synchronised; assertion stays asynchronous
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_sync_n = rst_s2_q;

    // A disabled channel never sets an alert; one already held stays until the next acquisition
    generate
        for (g = 0; g < AUX_N; g = g + 1) begin : g_aux
            wire [ADC_W-1:0] level;
            assign level = aux_input_voltage[g*ADC_W +: ADC_W];
            assign aux_over_hit[g] = aux_over_alert_enable[g] & (level > aux_over_threshold);
            assign aux_under_hit[g] = aux_under_alert_enable[g] & (level < aux_under_threshold);
        end
    endgenerate

    // The comparator decides the crossing; only the enable gates it here
    generate
        for (g = 0; g < CELL_N; g = g + 1) begin : g_cell
            assign cell_over_hit[g] = cell_over_alert_enable[g] & cmp_cell_above[g];
        end
    endgenerate

    // Fresh result replaces the bits, so a set bit survives until its own
    // engine finds the condition gone
    always @* begin
        aux_over_d = aux_over_q;
        aux_under_d = aux_under_q;
        if (adc_done) begin
            aux_over_d = aux_over_hit;
            aux_under_d = aux_under_hit;
        end
    end

    // Main acquisitions never reach the cell bits
    always @* begin
        cell_over_d = cell_over_q;
        if (cmp_done) begin
            cell_over_d = cell_over_hit;
        end
    end

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            aux_over_q <= RST_AUX_OVER;
        end else begin
            aux_over_q <= aux_over_d;
        end
    end

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            aux_under_q <= RST_AUX_UNDER;
        end else begin
            aux_under_q <= aux_under_d;
        end
    end

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cell_over_q <= RST_CELL_OVER;
        end else begin
            cell_over_q <= cell_over_d;
        end
    end

    assign aux_over_alert = aux_over_q;
    assign aux_under_alert = aux_under_q;
    assign cell_cmp_over_alert = cell_over_q;

    // Write data has nowhere to go; a write never answers
    assign rd_take = reg_rd & ~reg_wr;
    assign rd_sel = reg_select(reg_addr);

    // Unmapped offsets read zero
    always @* begin
        rdata_d = {`ACAS_DATA_W{1'b0}};
        case (rd_sel)
            SEL_AUX_OVER: begin
                rdata_d = widen_aux(aux_over_q);
            end
            SEL_AUX_UNDER: begin
                rdata_d = widen_aux(aux_under_q);
            end
            SEL_CELL_OVER: begin
                rdata_d = widen_cell(cell_over_q);
            end
            default: begin
                rdata_d = {`ACAS_DATA_W{1'b0}};
            end
        endcase
    end

    // Data holds between reads so a slow host may take it late
    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= {`ACAS_DATA_W{1'b0}};
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= rd_take;
            if (rd_take) begin
                reg_rdata <= rdata_d;
            end
        end
    end

endmodule
`default_nettype wire

// [bench/acas_chk_checker.sv]
// Purpose: Assertions on the alert bank ports
// Assumes: Bound to the bank top
// Notes: A read returns the alerts seen at its edge
`timescale 1ns/1ps
`default_nettype none
module acas_chk(input wire logic clk,rst_n,adc_done,cmp_done,reg_rd,reg_wr,reg_rvalid,
    input wire logic [7:0] reg_addr,input wire logic [15:0] reg_rdata,
    input wire logic [13:0] cell_cmp_over_alert,cmp_cell_above,cell_over_alert_enable,
    input wire logic [5:0] aux_over_alert,aux_under_alert,aux_over_alert_enable,aux_under_alert_enable);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_wr_silent: assert property (reg_wr |=> !reg_rvalid) else $error("write answered");
    a_over_en: assert property (adc_done |=> !(aux_over_alert & ~$past(aux_over_alert_enable)))
        else $error("over alert while disabled");
    a_under_en: assert property (adc_done |=> !(aux_under_alert & ~$past(aux_under_alert_enable)))
        else $error("under alert while disabled");
    a_aux_hold: assert property (!adc_done |=> $stable(aux_over_alert) && $stable(aux_under_alert))
        else $error("aux alert moved");
    a_cell_hold: assert property (!cmp_done |=> $stable(cell_cmp_over_alert)) else $error("cell alert moved");
    a_cell_set: assert property (cmp_done |=> cell_cmp_over_alert == ($past(cmp_cell_above) &
        $past(cell_over_alert_enable))) else $error("cell alert wrong");
    a_under_map: assert property (reg_rd && !reg_wr && reg_addr == 8'h0D |=>
        reg_rdata == {10'h000,$past(aux_under_alert)}) else $error("under read wrong");
    a_over_map: assert property (reg_rd && !reg_wr && reg_addr == 8'h0C |=>
        reg_rdata == {10'h000,$past(aux_over_alert)}) else $error("over read wrong");
    a_cell_map: assert property (reg_rd && !reg_wr && reg_addr == 8'h0E |=>
        reg_rdata == {2'h0,$past(cell_cmp_over_alert)}) else $error("cell read wrong");
endmodule
bind acas_alert_status acas_chk u_chk(.*);
`default_nettype wire

// [bench/acas_host.sv]
// Purpose: Host model issuing register cycles
// Assumes: Answer one cycle after the request edge
// Notes: Idle address is inverted, never left standing
`timescale 1ns/1ps
`default_nettype none
module acas_host(input wire logic clk,rv,input wire logic [15:0] rdata,output logic rd=1'h0,wr=1'h0,
    output logic [7:0] ad=8'h00);
    task automatic xfer(input logic w,input logic [7:0] a,output logic v,output logic [15:0] d);
        @(posedge clk);
        {rd,wr,ad} <= {!w,w,a};
        @(posedge clk);
        {rd,wr,ad} <= {2'h0,~a};
        #1 {v,d} = {rv,rdata};
    endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Purpose: Self-checking bench of the alert bank
// Assumes: Thresholds 100 and 50, all channels equal
// Notes: Row holds base, enables, over, under
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk=1'h0,rst_n=1'h0,ad=1'h0,cd=1'h0,v,rd,wr,rv;
    logic [7:0] a;
    logic [15:0] q,d;
    logic [13:0] b=14'h0000,ab=14'h0000,ce=14'h0000;
    logic [5:0] e=6'h00;
    logic [31:0] rows[4]='{{14'h0065,6'h2B,6'h2B,6'h00},{14'h0064,6'h3F,6'h00,6'h00},
        {14'h0031,6'h15,6'h00,6'h15},{14'h0032,6'h3F,6'h00,6'h00}};
    int n_mismatch=0,check_count=0;
    always #2.5 clk=~clk;
    acas_alert_status u_dut(.clk(clk),.rst_n(rst_n),.adc_done(ad),.aux_input_voltage({6{b}}),
        .aux_over_threshold(14'h0064),.aux_under_threshold(14'h0032),.aux_over_alert_enable(e),
        .aux_under_alert_enable(e),.cmp_done(cd),.cmp_cell_above(ab),.cell_over_alert_enable(ce),.reg_rd(rd),
        .reg_wr(wr),.reg_addr(a),.reg_wdata(16'hFFFF),.reg_rdata(q),.reg_rvalid(rv),.aux_over_alert(),
        .aux_under_alert(),.cell_cmp_over_alert());
    acas_host u_h(.clk(clk),.rv(rv),.rdata(q),.rd(rd),.wr(wr),.ad(a));
    task automatic chk(input string s,input logic [15:0] x,g);
        check_count++;
        if (g!==x) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h",s,x,g);
        end
    endtask
    task automatic rdc(input logic [7:0] r,input logic [15:0] x);
        u_h.xfer(1'h0,r,v,d);
        chk("rvalid",16'h0001,{15'h0000,v});
        chk("rdata",x,d);
    endtask
    task automatic pulse(input logic c);
        @(posedge clk);
        {ad,cd} <= {!c,c};
        @(posedge clk);
        {ad,cd} <= 2'h0;
    endtask
    task automatic end_sim;
        $display("counts: mismatches %0d checks %0d",n_mismatch,check_count);
        if (n_mismatch==0 && check_count>0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #20000;
        n_mismatch++;
        end_sim;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        for (int r=12;r<16;r++) rdc(r[7:0],16'h0000);
        {ab,ce} <= {14'h3FFF,14'h2001};
        pulse(1'h1);
        foreach (rows[i]) begin
            {b,e} <= rows[i][31:12];
            pulse(1'h0);
            rdc(8'h0C,{10'h000,rows[i][11:6]});
            rdc(8'h0D,{10'h000,rows[i][5:0]});
        end
        u_h.xfer(1'h1,8'h0E,v,d);
        chk("wr_rvalid",16'h0000,{15'h0000,v});
        rdc(8'h0E,16'h2001);
        ab <= 14'h0000;
        pulse(1'h1);
        rdc(8'h0E,16'h0000);
        {b,e} <= {14'h0065,6'h3F};
        pulse(1'h0);
        rdc(8'h0C,16'h003F);
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        rdc(8'h0C,16'h0000);
        end_sim;
    end
endmodule
`default_nettype wire
